// ==== src/crl_pkg.sv ====
// Package for the condition-logic and cache-maintenance execute unit
package crl_pkg;
	localparam int unsigned CRL_INSN_W = 32;
	localparam int unsigned CRL_ADDR_W = 32;
	localparam logic [5:0] CRL_OP_CRLOGIC = 6'h13;
	localparam logic [5:0] CRL_OP_EXT31 = 6'h1F;
	localparam logic [9:0] CRL_XO_OR = 10'h1C1;
	localparam logic [9:0] CRL_XO_ORC = 10'h1A1;
	localparam logic [9:0] CRL_XO_XOR = 10'h0C1;
	localparam logic [9:0] CRL_XO_FLUSH = 10'h056;
	localparam logic [9:0] CRL_XO_INVAL = 10'h1D6;
	localparam logic [9:0] CRL_XO_STORE = 10'h036;
	// Field positions as lsb index in little-endian bit numbering (bit 0 is the lsb)
	localparam int unsigned CRL_POS_PRIMARY = 26;
	localparam int unsigned CRL_POS_TARGET = 21;
	localparam int unsigned CRL_POS_SRCA = 16;
	localparam int unsigned CRL_POS_SRCB = 11;
	localparam int unsigned CRL_POS_XO = 1;
	localparam logic [31:0] CRL_CR_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		CRL_CMD_NONE = 2'h0,
		CRL_CMD_STORE = 2'h1,
		CRL_CMD_FLUSH = 2'h3,
		CRL_CMD_INVAL = 2'h2
	} crl_cmd_e;
	typedef enum logic [1:0] {
		CRL_ST_IDLE = 2'h0,
		CRL_ST_WAIT = 2'h1
	} crl_state_e;
endpackage

// ==== src/crl_decode.sv ====
// Instruction word decoder for the execute unit
module crl_decode
	import crl_pkg::*;
(
	// Instruction
	input wire logic [31:0] i_insn,
	// Decoded
	output logic o_is_or,
	output logic o_is_orc,
	output logic o_is_xor,
	output logic [4:0] o_target_cond_bit,
	output logic [4:0] o_first_source_cond_bit,
	output logic [4:0] o_second_source_cond_bit,
	output crl_pkg::crl_cmd_e o_cmd
);
	logic [5:0] primary;
	logic [9:0] xo;

	assign primary = i_insn[CRL_POS_PRIMARY +: 6];
	assign xo = i_insn[CRL_POS_XO +: 10];
	assign o_is_or = (primary == CRL_OP_CRLOGIC) && (xo == CRL_XO_OR);
	assign o_is_orc = (primary == CRL_OP_CRLOGIC) && (xo == CRL_XO_ORC);
	assign o_is_xor = (primary == CRL_OP_CRLOGIC) && (xo == CRL_XO_XOR);
	// Same field slots carry the address register numbers for the cache ops
	assign o_target_cond_bit = i_insn[CRL_POS_TARGET +: 5];
	assign o_first_source_cond_bit = i_insn[CRL_POS_SRCA +: 5];
	assign o_second_source_cond_bit = i_insn[CRL_POS_SRCB +: 5];

	always_comb begin
		o_cmd = CRL_CMD_NONE;
		if (primary == CRL_OP_EXT31) begin
			unique case (xo)
				CRL_XO_FLUSH: o_cmd = CRL_CMD_FLUSH;
				CRL_XO_INVAL: o_cmd = CRL_CMD_INVAL;
				CRL_XO_STORE: o_cmd = CRL_CMD_STORE;
				default: o_cmd = CRL_CMD_NONE;
			endcase
		end
	end
endmodule

// ==== src/crl_exec.sv ====
// Condition-logic and data-cache maintenance execute unit
module crl_exec
	import crl_pkg::*;
#(
	parameter int unsigned ADDR_W = CRL_ADDR_W
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Issue from pipeline
	input wire logic i_issue_valid,
	input wire logic [31:0] i_insn,
	input wire logic i_privileged,
	output logic o_issue_ready,
	// General-purpose register read
	output logic [4:0] o_base_addr_reg,
	output logic [4:0] o_index_addr_reg,
	input wire logic [ADDR_W-1:0] i_base_addr_reg_data,
	input wire logic [ADDR_W-1:0] i_index_addr_reg_data,
	// Condition register
	output logic [31:0] o_cond_reg,
	// Translation and protection
	output logic [ADDR_W-1:0] o_prot_addr,
	output logic o_prot_is_store,
	input wire logic i_prot_ok,
	input wire logic i_direct_store_seg,
	// Data-cache command
	output logic o_dc_req,
	output crl_pkg::crl_cmd_e o_dc_cmd,
	output logic [ADDR_W-1:0] o_dc_addr,
	input wire logic i_dc_present,
	input wire logic i_dc_modified,
	input wire logic i_dc_done,
	// Completion and exceptions
	output logic o_done,
	output logic o_priv_exc,
	output logic o_prot_exc,
	output logic o_xer_we
);
	import crl_pkg::*;

	logic is_or;
	logic is_orc;
	logic is_xor;
	logic [4:0] tgt;
	logic [4:0] srca;
	logic [4:0] srcb;
	crl_cmd_e dec_cmd;
	logic [ADDR_W-1:0] eff_addr;
	logic bit_a;
	logic bit_b;
	logic cr_result;
	logic accept;
	logic cache_go;
	logic [31:0] cond_reg_ff;
	crl_state_e state_ff;
	logic dc_req_ff;
	crl_cmd_e dc_cmd_ff;
	logic [ADDR_W-1:0] dc_addr_ff;
	logic done_ff;
	logic priv_exc_ff;
	logic prot_exc_ff;

	crl_decode u_decode (
		.i_insn(i_insn),
		.o_is_or(is_or),
		.o_is_orc(is_orc),
		.o_is_xor(is_xor),
		.o_target_cond_bit(tgt),
		.o_first_source_cond_bit(srca),
		.o_second_source_cond_bit(srcb),
		.o_cmd(dec_cmd)
	);

	// Bit 0 of the condition register is its msb
	assign bit_a = cond_reg_ff[5'd31 - srca];
	assign bit_b = cond_reg_ff[5'd31 - srcb];

	always_comb begin
		cr_result = 1'b0;
		if (is_or)
			cr_result = bit_a | bit_b;
		else if (is_orc)
			cr_result = bit_a | ~bit_b;
		else if (is_xor)
			cr_result = bit_a ^ bit_b;
	end

	// All three cache ops use the zero-base form of the address sum
	assign o_base_addr_reg = srca;
	assign o_index_addr_reg = srcb;
	assign eff_addr = (srca == 5'd0) ? i_index_addr_reg_data :
		i_base_addr_reg_data + i_index_addr_reg_data;
	assign o_prot_addr = eff_addr;
	// Invalidate is checked as a store, block store as a load
	assign o_prot_is_store = (dec_cmd == CRL_CMD_INVAL);

	assign o_issue_ready = (state_ff == CRL_ST_IDLE);
	assign accept = i_issue_valid && o_issue_ready;
	assign cache_go = accept && (dec_cmd != CRL_CMD_NONE) && i_prot_ok &&
		!i_direct_store_seg &&
		!((dec_cmd == CRL_CMD_INVAL) && !i_privileged);

	// No exception-register write from any op here
	assign o_xer_we = 1'b0;
	assign o_cond_reg = cond_reg_ff;
	assign o_dc_req = dc_req_ff;
	assign o_dc_cmd = dc_cmd_ff;
	assign o_dc_addr = dc_addr_ff;
	assign o_done = done_ff;
	assign o_priv_exc = priv_exc_ff;
	assign o_prot_exc = prot_exc_ff;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			cond_reg_ff <= CRL_CR_RST;
		else if (accept && (is_or || is_orc || is_xor))
			cond_reg_ff[5'd31 - tgt] <= cr_result;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			state_ff <= CRL_ST_IDLE;
		else begin
			unique case (state_ff)
				CRL_ST_IDLE: if (cache_go) state_ff <= CRL_ST_WAIT;
				CRL_ST_WAIT: if (i_dc_done) state_ff <= CRL_ST_IDLE;
				default: state_ff <= CRL_ST_IDLE;
			endcase
		end
	end

	// The cache performs write-back and invalidate as one command
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			dc_req_ff <= 1'b0;
			dc_cmd_ff <= CRL_CMD_NONE;
			dc_addr_ff <= '0;
		end else if (cache_go) begin
			dc_req_ff <= 1'b1;
			dc_cmd_ff <= dec_cmd;
			dc_addr_ff <= eff_addr;
		end else if (i_dc_done) begin
			dc_req_ff <= 1'b0;
			dc_cmd_ff <= CRL_CMD_NONE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			done_ff <= 1'b0;
			priv_exc_ff <= 1'b0;
			prot_exc_ff <= 1'b0;
		end else begin
			done_ff <= (accept && !cache_go) ||
				((state_ff == CRL_ST_WAIT) && i_dc_done);
			priv_exc_ff <= accept && (dec_cmd == CRL_CMD_INVAL) &&
				!i_privileged;
			prot_exc_ff <= accept && (dec_cmd != CRL_CMD_NONE) &&
				!i_direct_store_seg && !i_prot_ok &&
				!((dec_cmd == CRL_CMD_INVAL) && !i_privileged);
		end
	end

	// Command kinds the cache must act on for present blocks
	logic flush_like;
	assign flush_like = (dc_cmd_ff == CRL_CMD_FLUSH) ||
		(dc_cmd_ff == CRL_CMD_STORE);

	AST_OR_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_or |=> cond_reg_ff[5'd31 - $past(tgt)] ==
		($past(bit_a) | $past(bit_b)))
		else $error("or result wrong");
	AST_ORC_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_orc |=> cond_reg_ff[5'd31 - $past(tgt)] ==
		($past(bit_a) | ~$past(bit_b)))
		else $error("orc result wrong");
	AST_XOR_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_xor |=> cond_reg_ff[5'd31 - $past(tgt)] ==
		($past(bit_a) ^ $past(bit_b)))
		else $error("xor result wrong");
	AST_NO_XER: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!o_xer_we)
		else $error("exception register written");
	AST_FLUSH_ISSUE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go && dec_cmd == CRL_CMD_FLUSH |=>
		dc_req_ff && dc_cmd_ff == CRL_CMD_FLUSH &&
		dc_addr_ff == $past(eff_addr))
		else $error("flush not issued");
	AST_EA_ZERO_BASE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go && srca == 5'd0 |=>
		dc_addr_ff == $past(i_index_addr_reg_data))
		else $error("zero base address wrong");
	AST_EA_SUM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go && srca != 5'd0 |=> dc_addr_ff ==
		$past(i_base_addr_reg_data) + $past(i_index_addr_reg_data))
		else $error("address sum wrong");
	AST_DIRECT_NOP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && i_direct_store_seg |=> !dc_req_ff ##1 !dc_req_ff)
		else $error("direct-store access reached cache");
	AST_PRIV: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && dec_cmd == CRL_CMD_INVAL && !i_privileged |=>
		priv_exc_ff && !dc_req_ff && done_ff)
		else $error("unprivileged invalidate not trapped");
	AST_INV_PROT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dec_cmd == CRL_CMD_INVAL |-> o_prot_is_store)
		else $error("invalidate not store-checked");
	AST_BUSY_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dc_req_ff && !i_dc_done |=> dc_req_ff && $stable(dc_addr_ff)
		&& $stable(dc_cmd_ff))
		else $error("cache command dropped");
	AST_WB_CMD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dc_req_ff && i_dc_present && i_dc_modified |->
		flush_like || dc_cmd_ff == CRL_CMD_INVAL)
		else $error("bad cache command");

	COV_OR: cover property (@(posedge i_sys_clk) accept && is_or);
	COV_FLUSH: cover property (@(posedge i_sys_clk)
		cache_go && dec_cmd == CRL_CMD_FLUSH ##[1:20] i_dc_done);
	COV_INVAL: cover property (@(posedge i_sys_clk)
		cache_go && dec_cmd == CRL_CMD_INVAL);
	COV_PRIV: cover property (@(posedge i_sys_clk) priv_exc_ff);
	COV_STORE: cover property (@(posedge i_sys_clk)
		cache_go && dec_cmd == CRL_CMD_STORE);

	// Any of the three condition-bit operations
	logic is_cr_op;
	assign is_cr_op = is_or || is_orc || is_xor;

	// Decode checked against raw encodings, not the package constants,
	// so a wrong constant cannot hide behind itself
	AST_DEC_OR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h13 && i_insn[10:1] == 10'h1C1 |-> is_or)
		else $error("or not decoded");
	AST_DEC_ORC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h13 && i_insn[10:1] == 10'h1A1 |-> is_orc)
		else $error("orc not decoded");
	AST_DEC_XOR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h13 && i_insn[10:1] == 10'h0C1 |-> is_xor)
		else $error("xor not decoded");
	AST_DEC_FIELDS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		tgt == i_insn[25:21] && srca == i_insn[20:16] &&
		srcb == i_insn[15:11])
		else $error("bit index fields wrong");
	AST_DEC_FLUSH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h1F && i_insn[10:1] == 10'h056 |->
		dec_cmd == CRL_CMD_FLUSH)
		else $error("flush not decoded");
	AST_DEC_INVAL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h1F && i_insn[10:1] == 10'h1D6 |->
		dec_cmd == CRL_CMD_INVAL)
		else $error("invalidate not decoded");
	AST_DEC_STORE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_insn[31:26] == 6'h1F && i_insn[10:1] == 10'h036 |->
		dec_cmd == CRL_CMD_STORE)
		else $error("block store not decoded");

	// Condition register: only the target bit may move
	AST_CR_OTHERS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_cr_op |=>
		((cond_reg_ff ^ $past(cond_reg_ff)) &
		~(32'h0000_0001 << (5'd31 - $past(tgt)))) == 32'h0000_0000)
		else $error("non-target condition bit changed");
	AST_CR_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!(accept && is_cr_op) |=> $stable(cond_reg_ff))
		else $error("condition register changed without op");
	AST_CR_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_cr_op |=> o_done && !o_priv_exc && !o_prot_exc)
		else $error("condition op not completed");
	AST_CR_NO_REQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && is_cr_op |=> !o_dc_req)
		else $error("condition op reached cache");

	// Cache commands
	AST_INVAL_ISSUE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go && dec_cmd == CRL_CMD_INVAL |=>
		o_dc_req && o_dc_cmd == CRL_CMD_INVAL)
		else $error("invalidate not issued");
	AST_STORE_ISSUE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go && dec_cmd == CRL_CMD_STORE |=>
		o_dc_req && o_dc_cmd == CRL_CMD_STORE)
		else $error("block store not issued");
	AST_STORE_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dec_cmd == CRL_CMD_STORE |-> !o_prot_is_store)
		else $error("block store checked as store");
	AST_PROT_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		srca == 5'd0 |-> o_prot_addr == i_index_addr_reg_data)
		else $error("zero base check address wrong");
	AST_PROT_SUM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		srca != 5'd0 |-> o_prot_addr ==
		i_base_addr_reg_data + i_index_addr_reg_data)
		else $error("summed check address wrong");
	AST_PROT_BLOCK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && !i_prot_ok |=> !o_dc_req)
		else $error("protection failure reached cache");
	AST_PROT_EXC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && dec_cmd == CRL_CMD_INVAL && i_privileged &&
		!i_prot_ok && !i_direct_store_seg |=> o_prot_exc && o_done)
		else $error("protection fault not raised");
	AST_PRIV_OK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && dec_cmd == CRL_CMD_INVAL && i_privileged && i_prot_ok &&
		!i_direct_store_seg |=> o_dc_req && !o_priv_exc)
		else $error("privileged invalidate refused");
	AST_PRIV_ONLY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && dec_cmd != CRL_CMD_INVAL |=> !o_priv_exc)
		else $error("privilege fault on other op");

	// Completion tracks the cache answer
	AST_BUSY_READY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dc_req_ff |-> !o_issue_ready)
		else $error("ready while cache busy");
	AST_NO_EARLY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dc_req_ff && !i_dc_done |=> !o_done)
		else $error("done before cache answered");
	AST_CACHE_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dc_req_ff && i_dc_done |=> o_done && !o_dc_req && o_issue_ready)
		else $error("cache answer not completed");
	AST_DS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		accept && i_direct_store_seg && dec_cmd == CRL_CMD_FLUSH |=>
		o_done && !o_dc_req)
		else $error("direct-store flush not completed");
	AST_XER_CACHE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cache_go |=> !o_xer_we)
		else $error("cache op wrote exception register");
endmodule

// ==== test/crl_cache_model.sv ====
// Data-cache model that answers maintenance commands after a set latency
module crl_cache_model
	import crl_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Command from the unit
	input wire logic i_req,
	input wire crl_cmd_e i_cmd,
	input wire logic i_mod,
	input wire logic [3:0] i_lat,
	// Answer and bookkeeping
	output logic o_done,
	output int o_wb_cnt,
	output int o_inv_cnt
);
	logic [3:0] wait_ff;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wait_ff <= 4'h0;
			o_done <= 1'b0;
			o_wb_cnt <= 0;
			o_inv_cnt <= 0;
		end else if (!i_req || o_done) begin
			// Done is a single pulse; req falls on the edge that sees it
			wait_ff <= 4'h0;
			o_done <= 1'b0;
		end else if (wait_ff == i_lat) begin
			o_done <= 1'b1;
			if (i_mod && i_cmd != CRL_CMD_INVAL)
				o_wb_cnt <= o_wb_cnt + 1;
			if (i_cmd != CRL_CMD_STORE)
				o_inv_cnt <= o_inv_cnt + 1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule

// ==== test/test_cr_logic_cache_op_decode.sv ====
// Self-checking bench for the condition-logic and cache-op unit
module test_cr_logic_cache_op_decode;
	timeunit 1ns;
	timeprecision 1ps;
	import crl_pkg::*;
	logic clk = 0, rst = 1, valid = 0, priv = 0, ok = 1, ds = 0, mod = 0;
	logic [31:0] insn = 0, exp_cr = 0;
	logic [3:0] lat = 0;
	logic ready, done, pexc, rexc, xer, req, pst, dcd;
	logic [4:0] ra, rb;
	logic [31:0] cr, pa, da, bd, id;
	crl_cmd_e cmd;
	int wbc, invc, miscompares = 0, checks = 0;
	function automatic logic [31:0] gpr(input logic [4:0] r);
		return {3'h0, r, 24'h00_0040};
	endfunction
	always #5 clk = ~clk;
	assign bd = gpr(ra);
	assign id = gpr(rb);
	crl_exec i_crl_exec (.i_sys_clk(clk), .i_rst(rst), .i_issue_valid(valid),
		.i_insn(insn), .i_privileged(priv), .o_issue_ready(ready),
		.o_base_addr_reg(ra), .o_index_addr_reg(rb),
		.i_base_addr_reg_data(bd), .i_index_addr_reg_data(id),
		.o_cond_reg(cr), .o_prot_addr(pa), .o_prot_is_store(pst),
		.i_prot_ok(ok), .i_direct_store_seg(ds), .o_dc_req(req),
		.o_dc_cmd(cmd), .o_dc_addr(da), .i_dc_present(1'b1),
		.i_dc_modified(mod), .i_dc_done(dcd), .o_done(done),
		.o_priv_exc(pexc), .o_prot_exc(rexc), .o_xer_we(xer));
	crl_cache_model i_crl_cache_model (.i_sys_clk(clk), .i_rst(rst),
		.i_req(req), .i_cmd(cmd), .i_mod(mod), .i_lat(lat), .o_done(dcd),
		.o_wb_cnt(wbc), .o_inv_cnt(invc));
	task automatic check(input logic [31:0] seen, exp, input string msg);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic offer(input logic [31:0] w, input logic p, k, d, m);
		@(posedge clk);
		valid <= 1'b1;
		insn <= w;
		priv <= p;
		ok <= k;
		ds <= d;
		mod <= m;
		#1;
	endtask
	task automatic take();
		@(posedge clk);
		valid <= 1'b0;
		#1;
		check(xer, 0, "exception register written");
	endtask
	task automatic cr_op(input logic [9:0] xo, input logic [4:0] t, a, b);
		logic va, vb;
		va = exp_cr[31-a];
		vb = exp_cr[31-b];
		exp_cr[31-t] = (xo == CRL_XO_XOR) ? va ^ vb :
			(xo == CRL_XO_OR) ? va | vb : va | ~vb;
		offer({CRL_OP_CRLOGIC, t, a, b, xo, 1'b0}, 1, 1, 0, 0);
		take();
		check(cr, exp_cr, "condition register");
		check(done, 1, "cr op done");
	endtask
	// kind: 0 command, 1 done only, 2 privilege fault, 3 protection fault
	task automatic cache_op(input logic [9:0] xo, input logic [4:0] a, b,
		input logic p, k, d, m, input logic [3:0] l, input int kind);
		int w0, i0, n;
		logic [31:0] ea;
		crl_cmd_e ec;
		ea = (a == 5'h0 ? 32'h0 : gpr(a)) + gpr(b);
		ec = xo == CRL_XO_FLUSH ? CRL_CMD_FLUSH :
			xo == CRL_XO_INVAL ? CRL_CMD_INVAL : CRL_CMD_STORE;
		w0 = wbc;
		i0 = invc;
		lat <= l;
		offer({CRL_OP_EXT31, 5'h0, a, b, xo, 1'b0}, p, k, d, m);
		if (kind == 0) begin
			check(pa, ea, "protection address");
			check(pst, xo == CRL_XO_INVAL, "store check");
		end
		take();
		if (kind == 0) begin
			check(req, 1, "no cache request");
			check({30'h0, cmd}, {30'h0, ec}, "cache command");
			check(da, ea, "cache address");
			check(ready, 0, "ready while busy");
			n = 0;
			while (done !== 1'b1 && n < 40) begin
				@(posedge clk);
				#1;
				n++;
			end
			check(wbc - w0, m && ec != CRL_CMD_INVAL, "write-back");
			check(invc - i0, ec != CRL_CMD_STORE, "invalidate");
		end else begin
			check(req, 0, "suppressed request");
			check(pexc, kind == 2, "privilege fault");
			check(rexc, kind == 3, "protection fault");
		end
		check(done, 1, "cache op done");
	endtask
	task automatic test_cr();
		cr_op(CRL_XO_ORC, 0, 0, 0);
		cr_op(CRL_XO_OR, 4, 8, 0);
		cr_op(CRL_XO_XOR, 4, 4, 0);
		cr_op(CRL_XO_ORC, 9, 4, 0);
		cr_op(CRL_XO_XOR, 31, 0, 9);
		cr_op(CRL_XO_OR, 20, 9, 17);
		cr_op(CRL_XO_ORC, 17, 17, 31);
		$display("test_cr done");
	endtask
	task automatic test_flush();
		cache_op(CRL_XO_FLUSH, 0, 7, 1, 1, 0, 1, 0, 0);
		cache_op(CRL_XO_FLUSH, 3, 7, 0, 1, 0, 0, 3, 0);
		cache_op(CRL_XO_FLUSH, 3, 4, 1, 1, 1, 1, 0, 1);
		$display("test_flush done");
	endtask
	task automatic test_inval();
		cache_op(CRL_XO_INVAL, 5, 2, 1, 1, 0, 1, 2, 0);
		cache_op(CRL_XO_INVAL, 0, 2, 1, 1, 0, 0, 0, 0);
		cache_op(CRL_XO_INVAL, 5, 2, 0, 1, 0, 0, 0, 2);
		cache_op(CRL_XO_INVAL, 5, 2, 1, 0, 0, 0, 0, 3);
		$display("test_inval done");
	endtask
	task automatic test_store();
		cache_op(CRL_XO_STORE, 1, 6, 1, 1, 0, 1, 1, 0);
		cache_op(CRL_XO_STORE, 1, 6, 0, 1, 0, 0, 0, 0);
		cache_op(10'h116, 1, 6, 1, 1, 0, 0, 0, 1);
		$display("test_store done");
	endtask
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(cr, CRL_CR_RST, "reset condition register");
		check(ready, 1, "reset ready");
		test_cr();
		test_flush();
		test_inval();
		test_store();
		final_report();
	end
endmodule
